// ---- core/psc_core.sv ----
// pin-level control of a pipelined burst sram with apb side registers
//
// How it works
// - core acts on a clock rise only while clock_gate_n is low
// - clock_gate_n high freezes pipeline, burst count, storage and read data, not the drive enable, and does not deselect
// - input data is taken into storage on the rising clock edge
// - read data driven is the word addressed at the preceding rise
// - data lines drive only while output_drive_n is low
// - float on write data phase, after deselect and while deselected
// - parity lines follow data lines, written per byte-lane select
// - strap high gives interleaved burst order, low gives linear
// - an open strap reads high through the pad, so interleaved
// - scan_out changes on the falling edge of the test clock
// - scan_in is sampled on the rising edge of the test clock
// - scan_mode_sel steers the tap machine on the test clock rise
// - sleep_request high enters sleep and keeps the stored words
// - sleep_request is low or open in use; the pad pulls it down
// - advance_or_load high steps the burst counter, low loads address
// - burst counter steps the two low address bits, wraps after four
`timescale 1ns/100ps
module psc_core
  import psc_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire psc_pkg::psc_apb_req_t     apb_req,
  output psc_pkg::psc_apb_rsp_t          apb_rsp,
  input  wire logic                      clock_gate_n,
  input  wire logic                      chip_sel1_n,
  input  wire logic                      chip_sel2,
  input  wire logic                      chip_sel3_n,
  input  wire logic                      write_n,
  input  wire logic                      advance_or_load,
  input  wire logic [psc_pkg::LANES-1:0]  byte_lane_write_n,
  input  wire logic [psc_pkg::ADDR_W-1:0] addr,
  input  wire psc_pkg::psc_word_t        data_in,
  output psc_pkg::psc_word_t             data_out,
  output logic                           data_oe_n,
  input  wire logic                      output_drive_n,
  input  wire logic                      burst_order_strap,
  input  wire logic                      sleep_request,
  input  wire logic                      scan_clk,
  input  wire logic                      scan_mode_sel,
  input  wire logic                      scan_in,
  output logic                           scan_out,
  output logic                           snoop_ready
);

  import psc_pkg::*;

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [5:0]        pin_meta;
  logic [5:0]        pin_sync;
  logic              tck_last;
  logic [1:0]        strap_cnt;
  logic              interleave;
  logic              sleep_active;
  psc_op_t           op1;
  psc_op_t           op2;
  logic [ADDR_W-1:0] base_addr;
  logic [1:0]        burst_cnt;
  logic              burst_valid;
  logic              burst_write;
  logic              read_valid;
  logic [31:0]       ctrl;
  psc_word_t         fifo_mem [FIFO_DEPTH];
  logic              fifo_wp;
  logic              fifo_rp;
  logic [1:0]        fifo_cnt;
  psc_tap_t          tap_state;
  psc_tap_t          next_tap;
  logic [1:0]        ir;
  logic              bypass;
  psc_word_t         rd_word;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  wire [5:0] pin_raw = {sleep_request, output_drive_n, burst_order_strap,
                        scan_clk, scan_mode_sel, scan_in};

  // two flops on every asynchronous pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= SYNC_RST;
      pin_sync <= SYNC_RST;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire sleep_s = pin_sync[5];
  wire oe_n_s  = pin_sync[4];
  wire strap_s = pin_sync[3];
  wire tck_s   = pin_sync[2];
  wire tms_s   = pin_sync[1];
  wire tdi_s   = pin_sync[0];

  // ------------------------------------------------------------------
  // strap and sleep
  // ------------------------------------------------------------------
  // strap taken once, after the synchroniser has filled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt  <= 2'h0;
      interleave <= 1'b1;
    end else if (strap_cnt != STRAP_WAIT) begin
      strap_cnt  <= strap_cnt + 2'h1;
      interleave <= strap_s;
    end
  end

  // sleep follows the pin, storage is never touched by it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_active <= 1'b0;
    end else begin
      sleep_active <= sleep_s;
    end
  end

  // ------------------------------------------------------------------
  // core qualification and op decode
  // ------------------------------------------------------------------
  wire capture_en = ctrl[CTRL_CAPTURE_BIT];
  wire op2_wr     = op2.valid & op2.write;
  wire fifo_full  = (fifo_cnt == FIFO_DEPTH);
  wire fifo_stall = capture_en & op2_wr & fifo_full;
  wire core_en    = ~clock_gate_n & ~fifo_stall;
  wire selected   = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n & ~sleep_active;
  wire load       = ~advance_or_load;

  // burst address low bits in the order picked by the strap
  wire [1:0] cnt_inc  = burst_cnt + 2'h1;
  wire [1:0] start_lo = base_addr[1:0];
  wire [1:0] ilv_lo   = start_lo ^ cnt_inc;
  wire [1:0] lin_lo   = start_lo + cnt_inc;
  wire [1:0] burst_lo = interleave ? ilv_lo : lin_lo;
  wire [ADDR_W-1:0] burst_addr = {base_addr[ADDR_W-1:2], burst_lo};

  // a load takes fresh pins, an advance repeats the latched op type
  wire psc_op_t load_op = '{valid:  selected,
                            write:  ~write_n,
                            addr:   addr,
                            lane_n: byte_lane_write_n};
  wire psc_op_t adv_op  = '{valid:  burst_valid & ~sleep_active,
                            write:  burst_write,
                            addr:   burst_addr,
                            lane_n: byte_lane_write_n};
  wire psc_op_t next_op1 = load ? load_op : adv_op;

  // ------------------------------------------------------------------
  // address pipeline and burst counter
  // ------------------------------------------------------------------
  // held whole while the clock is gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op1 <= '0;
      op2 <= '0;
    end else if (core_en) begin
      op1 <= next_op1;
      op2 <= op1;
    end
  end

  // load restarts the count, advance steps and wraps it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_addr   <= '0;
      burst_cnt   <= 2'h0;
      burst_valid <= 1'b0;
      burst_write <= 1'b0;
    end else if (core_en && load) begin
      base_addr   <= addr;
      burst_cnt   <= 2'h0;
      burst_valid <= selected;
      burst_write <= ~write_n;
    end else if (core_en) begin
      burst_cnt   <= cnt_inc;
    end
  end

  // ------------------------------------------------------------------
  // storage, one array per byte lane with its parity bit
  // ------------------------------------------------------------------
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W:0] store [DEPTH];
    wire             lane_wr = op2_wr & ~op2.lane_n[g];
    wire [LANE_W:0]  pin_v   = {data_in.par[g],
                                data_in.data[g*LANE_W +: LANE_W]};
    wire             fwd     = lane_wr & (op2.addr == op1.addr);
    wire [LANE_W:0]  rd_v    = fwd ? pin_v : store[op1.addr];

    // write data taken at the rise after the dead cycle
    always_ff @(posedge pclk) begin
      if (core_en && lane_wr) begin
        store[op2.addr] <= pin_v;
      end
    end

    assign rd_word.par[g]                     = rd_v[LANE_W];
    assign rd_word.data[g*LANE_W +: LANE_W]   = rd_v[LANE_W-1:0];
  end

  // ------------------------------------------------------------------
  // output register and drive control
  // ------------------------------------------------------------------
  wire op1_rd     = op1.valid & ~op1.write;
  wire next_rvld  = core_en ? op1_rd : read_valid;
  wire next_drive = next_rvld & ~oe_n_s & ~sleep_s;

  // data of the op captured one rise earlier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_valid <= 1'b0;
      data_out   <= '0;
    end else if (core_en) begin
      read_valid <= op1_rd;
      if (op1_rd) begin
        data_out <= rd_word;
      end
    end
  end

  // enable tracks the drive pin even while gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= ~next_drive;
    end
  end

  // ------------------------------------------------------------------
  // write capture buffer
  // ------------------------------------------------------------------
  wire apb_first = apb_req.psel & apb_req.penable & ~apb_rsp.pready;
  wire apb_done  = apb_req.psel & apb_req.penable & apb_rsp.pready;
  wire hit_ctrl  = (apb_req.paddr == CTRL_OFF);
  wire hit_stat  = (apb_req.paddr == STATUS_OFF);
  wire hit_cdat  = (apb_req.paddr == CAP_DATA_OFF);
  wire hit_cpar  = (apb_req.paddr == CAP_PAR_OFF);
  wire push      = core_en & capture_en & op2_wr;
  wire pop       = apb_done & ~apb_req.pwrite & hit_cdat & (fifo_cnt != 2'h0);
  wire [1:0] next_cnt = fifo_cnt + {1'b0, push} - {1'b0, pop};

  // two entries; a full buffer stalls the core rather than drop a word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_wp     <= 1'b0;
      fifo_rp     <= 1'b0;
      fifo_cnt    <= 2'h0;
      snoop_ready <= 1'b1;
    end else begin
      fifo_wp     <= fifo_wp ^ push;
      fifo_rp     <= fifo_rp ^ pop;
      fifo_cnt    <= next_cnt;
      snoop_ready <= (next_cnt != FIFO_DEPTH);
    end
  end

  // entry storage
  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_mem[fifo_wp] <= data_in;
    end
  end

  // ------------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------------
  wire mapped   = hit_ctrl | hit_stat | hit_cdat | hit_cpar;
  wire bad_wr   = apb_req.pwrite & ~hit_ctrl;
  psc_word_t fifo_head;
  assign fifo_head = fifo_mem[fifo_rp];

  wire [31:0] stat_word = {20'h0_0000, tap_state, 1'b0, burst_cnt,
                           ~data_oe_n, fifo_cnt, interleave, sleep_active};
  wire [31:0] cpar_word = {28'h000_0000, fifo_head.par};
  wire [31:0] rd_mux    = hit_ctrl ? ctrl :
                          hit_stat ? stat_word :
                          hit_cdat ? fifo_head.data :
                          hit_cpar ? cpar_word : 32'h0000_0000;

  // one wait state, answer sampled at the second access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= apb_first;
      if (apb_first) begin
        apb_rsp.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
        apb_rsp.pslverr <= ~mapped | bad_wr;
      end
    end
  end

  // control word, written at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
    end else if (apb_done && apb_req.pwrite && hit_ctrl) begin
      ctrl <= {31'h0000_0000, apb_req.pwdata[CTRL_CAPTURE_BIT]};
    end
  end

  // ------------------------------------------------------------------
  // scan port
  // ------------------------------------------------------------------
  wire tck_rise = tck_s & ~tck_last;
  wire tck_fall = ~tck_s & tck_last;

  // tap state step chosen by the mode select
  always_comb begin
    next_tap = tap_state;
    case (tap_state)
      TAP_RESET:  next_tap = tms_s ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tap = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  next_tap = tms_s ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tap = tms_s ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  next_tap = tms_s ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
      default:    next_tap = TAP_RESET;
    endcase
  end

  // state and shift paths move on the test clock rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_last  <= 1'b0;
      tap_state <= TAP_RESET;
      ir        <= IR_CAPTURE;
      bypass    <= 1'b0;
    end else begin
      tck_last <= tck_s;
      if (tck_rise) begin
        tap_state <= next_tap;
        case (tap_state)
          TAP_CAP_IR: ir     <= IR_CAPTURE;
          TAP_SH_IR:  ir     <= {tdi_s, ir[1]};
          TAP_CAP_DR: bypass <= 1'b0;
          TAP_SH_DR:  bypass <= tdi_s;
          default:    bypass <= bypass;
        endcase
      end
    end
  end

  // serial out moves on the test clock fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_out <= 1'b0;
    end else if (tck_fall) begin
      scan_out <= (tap_state == TAP_SH_IR) ? ir[0] :
                  (tap_state == TAP_SH_DR) ? bypass : 1'b0;
    end
  end

endmodule

// ---- core/psc_pkg.sv ----
// shared constants, types and register map of the pipelined sram pin block
package psc_pkg;

  // ------------------------------------------------------------------
  // array shape
  // ------------------------------------------------------------------
  localparam int LANES  = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = LANES * LANE_W;
  localparam int ADDR_W = 4;
  localparam int DEPTH  = 16;
  localparam int APB_AW = 8;

  // ------------------------------------------------------------------
  // register map and field positions
  // ------------------------------------------------------------------
  localparam logic [APB_AW-1:0] CTRL_OFF     = 8'h00;
  localparam logic [APB_AW-1:0] STATUS_OFF   = 8'h04;
  localparam logic [APB_AW-1:0] CAP_DATA_OFF = 8'h08;
  localparam logic [APB_AW-1:0] CAP_PAR_OFF  = 8'h0C;
  localparam logic [31:0]       CTRL_RST     = 32'h0000_0000;
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam int STAT_SLEEP_BIT   = 0;
  localparam int STAT_ILV_BIT     = 1;
  localparam int STAT_FILL_LSB    = 2;
  localparam int STAT_DRIVE_BIT   = 4;
  localparam int STAT_BURST_LSB   = 5;
  localparam int STAT_TAP_LSB     = 8;

  // ------------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------------
  localparam logic [5:0] SYNC_RST    = 6'h1A; // oe_n, strap, tms high
  localparam logic [1:0] STRAP_WAIT  = 2'h3;  // edges before strap is taken
  localparam logic [1:0] IR_CAPTURE  = 2'h1;
  localparam logic [1:0] FIFO_DEPTH  = 2'h2;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [LANES-1:0]  par;
    logic [DATA_W-1:0] data;
  } psc_word_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_n;
  } psc_op_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } psc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } psc_apb_rsp_t;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } psc_tap_t;

endpackage

// ---- test/psc_core_props.sv ----
// assertions on the pins and apb port of psc_core
`timescale 1ns/100ps
module psc_core_props
  import psc_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire psc_pkg::psc_apb_req_t apb_req,
  input wire psc_pkg::psc_apb_rsp_t apb_rsp,
  input wire logic                  clock_gate_n,
  input wire logic                  chip_sel1_n,
  input wire logic                  chip_sel2,
  input wire logic                  chip_sel3_n,
  input wire logic                  write_n,
  input wire logic                  advance_or_load,
  input wire psc_pkg::psc_word_t    data_out,
  input wire logic                  data_oe_n,
  input wire logic                  output_drive_n,
  input wire logic                  sleep_request,
  input wire logic                  scan_clk,
  input wire logic                  scan_out
);
  // --------------------
  // control decode
  // --------------------
  wire sel_ok = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
  wire ld     = !clock_gate_n && !advance_or_load;
  wire quiet  = !output_drive_n && !sleep_request;
  wire acc    = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // --------------------
  // properties
  // --------------------
  a_gated_hold: assert property (
    clock_gate_n |=> $stable(data_out))
    else $error("read data moved on a gated edge");
  a_float_cases: assert property (
    ld && (!sel_ok || !write_n) ##1 !clock_gate_n |=> data_oe_n)
    else $error("drive after write or deselect");
  a_read_drive: assert property (
    quiet[*5] ##0 (ld && sel_ok && write_n) ##1 (quiet && !clock_gate_n)
    |=> !data_oe_n)
    else $error("read result not driven");
  a_drive_mask: assert property (
    (output_drive_n || sleep_request)[*5] |-> data_oe_n)
    else $error("drive while masked");
  a_apb_wait: assert property (
    acc |=> apb_rsp.pready)
    else $error("apb answer not after one wait");
  a_pready_pulse: assert property (
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (
    acc && apb_req.paddr > CAP_PAR_OFF
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ro_write: assert property (
    acc && apb_req.pwrite && apb_req.paddr != CTRL_OFF |=> apb_rsp.pslverr)
    else $error("read-only write not refused");
  a_scan_fall: assert property (
    $changed(scan_out) |-> !scan_clk)
    else $error("scan output moved while test clock high");
endmodule

bind psc_core psc_core_props u_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .clock_gate_n(clock_gate_n), .chip_sel1_n(chip_sel1_n),
  .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n), .write_n(write_n),
  .advance_or_load(advance_or_load), .data_out(data_out),
  .data_oe_n(data_oe_n), .output_drive_n(output_drive_n),
  .sleep_request(sleep_request), .scan_clk(scan_clk), .scan_out(scan_out)
);

// ---- test/psc_bus_model.sv ----
// controller-side model of the shared data and parity wires
`timescale 1ns/100ps
module psc_bus_model
  import psc_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               clock_gate_n,
  input  wire logic               wr_beat,
  input  wire psc_pkg::psc_word_t wr_word,
  input  wire psc_pkg::psc_word_t data_out,
  input  wire logic               data_oe_n,
  output psc_pkg::psc_word_t      data_in,
  output logic                    clash
);
  psc_word_t w1   = '0;
  psc_word_t w2   = '0;
  psc_word_t last = '0;
  logic      e1   = 1'b0;
  logic      e2   = 1'b0;

  // write data trails its beat by two edges, stalls when gated
  always @(posedge pclk) begin
    if (!clock_gate_n) begin
      e1 <= wr_beat;
      w1 <= wr_word;
      e2 <= e1;
      w2 <= w1;
    end
    last <= data_in;
  end

  // released wires drift away from the last value seen
  assign data_in = e2 ? w2 : (!data_oe_n ? data_out : ~last);
  assign clash   = e2 && !data_oe_n;
endmodule

// ---- test/psc_core_tb.sv ----
// self-checking bench for psc_core with a controller wire model
`timescale 1ns/100ps
module psc_core_tb;
  import psc_pkg::*;
  psc_apb_req_t apb_req;
  psc_apb_rsp_t apb_rsp;
  psc_word_t    data_in, data_out, wr_word;
  psc_word_t    mem [DEPTH];
  logic         pclk = 1'b0, clash_seen = 1'b0;
  logic         presetn, clock_gate_n, write_n, advance_or_load, wr_beat;
  logic         chip_sel1_n, chip_sel2, chip_sel3_n, data_oe_n, clash;
  logic         output_drive_n, burst_order_strap, sleep_request, er;
  logic         scan_clk, scan_mode_sel, scan_in, scan_out, snoop_ready;
  logic [3:0]   addr, byte_lane_write_n;
  logic [31:0]  rd;
  int           err_total = 0, n_checks = 0;

  psc_core u_dut (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .clock_gate_n(clock_gate_n), .chip_sel1_n(chip_sel1_n),
    .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n), .write_n(write_n),
    .advance_or_load(advance_or_load), .addr(addr), .data_in(data_in),
    .byte_lane_write_n(byte_lane_write_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .output_drive_n(output_drive_n),
    .burst_order_strap(burst_order_strap), .sleep_request(sleep_request),
    .scan_clk(scan_clk), .scan_mode_sel(scan_mode_sel), .scan_in(scan_in),
    .scan_out(scan_out), .snoop_ready(snoop_ready)
  );
  psc_bus_model u_wires (
    .pclk(pclk), .clock_gate_n(clock_gate_n), .wr_beat(wr_beat),
    .wr_word(wr_word), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in), .clash(clash)
  );
  // clock and contention watch
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (clash === 1'b1) clash_seen <= 1'b1;

  // --------------------
  // helpers
  // --------------------
  task automatic chk(input string what, input logic [35:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one apb transfer held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  // one sram cycle; sn holds the three selects as active-low bits
  task automatic sram(input logic gn, adv, w, input logic [2:0] sn,
                      input logic [3:0] a, bw, input psc_word_t d);
    @(posedge pclk);
    clock_gate_n      <= gn;
    advance_or_load   <= adv;
    write_n           <= !w;
    chip_sel1_n       <= sn[0];
    chip_sel2         <= !sn[1];
    chip_sel3_n       <= sn[2];
    addr              <= a;
    byte_lane_write_n <= bw;
    wr_beat           <= w;
    wr_word           <= d;
  endtask
  task automatic idle;
    sram(1'b0, 1'b0, 1'b0, 3'h7, 4'h0, 4'hF, '0);
  endtask
  function automatic psc_word_t merge(psc_word_t o, n, logic [3:0] bw);
    for (int g = 0; g < LANES; g++) begin
      if (!bw[g]) begin
        o.data[g*LANE_W +: LANE_W] = n.data[g*LANE_W +: LANE_W];
        o.par[g] = n.par[g];
      end
    end
    return o;
  endfunction
  task automatic wr(input logic [3:0] a, bw, input psc_word_t d);
    sram(1'b0, 1'b0, 1'b1, 3'h0, a, bw, d);
    mem[a] = merge(mem[a], d, bw);
  endtask
  // read, then judge data and drive one edge after the load
  task automatic rdc(input logic [3:0] a, input logic drv);
    sram(1'b0, 1'b0, 1'b0, 3'h0, a, 4'hF, '0);
    idle;
    @(posedge pclk);
    #1;
    chk("read word", mem[a], data_out);
    chk("drive enable", !drv, data_oe_n);
  endtask
  task automatic do_reset(input logic s);
    @(posedge pclk);
    presetn           <= 1'b0;
    burst_order_strap <= s; // changed only inside reset
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic tck(input logic tms, tdi);
    @(posedge pclk);
    scan_mode_sel <= tms;
    scan_in       <= tdi;
    repeat (8) @(posedge pclk);
    scan_clk <= 1'b1;
    repeat (8) @(posedge pclk);
    scan_clk <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  // --------------------
  // scenarios
  // --------------------
  task automatic test_regs;
    chk("idle drive", 1, data_oe_n);
    apb(1'b1, CTRL_OFF, 32'h1);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl", 1, rd);
    apb(1'b1, STATUS_OFF, 32'hFFFF);
    chk("ro write refused", 1, er);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped refused", 1, er);
    apb(1'b1, CTRL_OFF, 32'h0);
    $display("test regs done");
  endtask
  task automatic test_lanes_gate;
    psc_word_t prev;
    wr(4'h2, 4'h0, {4'hA, 32'h1122_3344});
    wr(4'h2, 4'hA, {4'h5, 32'hAABB_CCDD});
    rdc(4'h2, 1'b1); // write then read back to back
    wr(4'h3, 4'h0, {4'h3, 32'h3333_0303});
    rdc(4'h2, 1'b1);
    prev = data_out;
    sram(1'b0, 1'b0, 1'b0, 3'h0, 4'h3, 4'hF, '0);
    sram(1'b1, 1'b0, 1'b0, 3'h7, 4'h0, 4'hF, '0);
    repeat (3) begin
      @(posedge pclk);
      #1;
      chk("gated hold", prev, data_out);
    end
    idle;
    @(posedge pclk);
    #1;
    chk("read after gate", mem[3], data_out);
    $display("test lanes done");
  endtask
  task automatic test_mask;
    @(posedge pclk);
    output_drive_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(4'h2, 1'b0);
    @(posedge pclk);
    output_drive_n <= 1'b0;
    sleep_request  <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("sleep flag", 1, rd[STAT_SLEEP_BIT]);
    @(posedge pclk);
    sleep_request <= 1'b0;
    repeat (6) @(posedge pclk);
    rdc(4'h3, 1'b1); // contents kept
    $display("test drive mask and sleep done");
  endtask
  task automatic test_buf;
    apb(1'b1, CTRL_OFF, 32'h1);
    wr(4'h6, 4'h0, {4'h6, 32'h6666_0006});
    wr(4'h7, 4'h0, {4'h7, 32'h7777_0007});
    repeat (3) idle;
    #1;
    chk("buffer full", 0, snoop_ready);
    for (int i = 6; i < 8; i++) begin
      apb(1'b0, CAP_PAR_OFF, 32'h0);
      chk("captured parity", mem[i].par, rd[3:0]);
      apb(1'b0, CAP_DATA_OFF, 32'h0);
      chk("captured data", mem[i].data, rd);
    end
    @(posedge pclk);
    #1;
    chk("buffer empty", 1, snoop_ready);
    apb(1'b1, CTRL_OFF, 32'h0);
    $display("test buffer done");
  endtask
  task automatic test_tap;
    tck(1'b0, 1'b0);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("tap idle", 1, rd[11:8]);
    tck(1'b1, 1'b0);
    tck(1'b1, 1'b0);
    tck(1'b0, 1'b0);
    tck(1'b0, 1'b0);
    chk("scan capture bit", 1, scan_out);
    tck(1'b0, 1'b1);
    chk("scan shifted bit", 0, scan_out);
    tck(1'b0, 1'b1);
    chk("scan input bit", 1, scan_out);
    $display("test scan done");
  endtask
  task automatic test_burst(input logic ilv);
    logic [3:0] a;
    psc_word_t  d;
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("burst order flag", ilv, rd[STAT_ILV_BIT]);
    for (int k = 0; k < 4; k++) begin
      a = {2'b01, ilv ? 2'(2'b01 ^ k) : 2'(2'b01 + k)};
      d = {4'(k), 32'hB000_0000 + 32'(k) + (ilv ? 32'h100 : 32'h0)};
      sram(1'b0, k != 0, 1'b1, (k == 0) ? 3'h0 : 3'h7, 4'h5, 4'h0, d);
      mem[a] = d;
    end
    idle;
    for (int k = 4; k < 8; k++) begin
      rdc(4'(k), 1'b1);
    end
    $display("test burst done");
  endtask

  // --------------------
  // main sequence and watchdog
  // --------------------
  initial begin
    {presetn, write_n, advance_or_load, wr_beat} = 4'h0;
    {chip_sel1_n, chip_sel2, chip_sel3_n, clock_gate_n} = 4'hF;
    {sleep_request, output_drive_n, scan_clk, scan_mode_sel} = 4'h1;
    {scan_in, burst_order_strap} = 2'h1;
    {addr, byte_lane_write_n} = 8'h0F;
    apb_req = '0;
    wr_word = '0;
    do_reset(1'b1);
    test_regs;
    test_lanes_gate;
    test_mask;
    test_buf;
    test_tap;
    test_burst(1'b1);
    do_reset(1'b0);
    test_burst(1'b0);
    chk("bus clash", 0, clash_seen);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("watchdog expired");
    report_and_stop;
  end
endmodule
